// >>> vfd_pkg.sv
// Shared constants, types and register map of the display scan controller
package vfd_pkg;

    // Output widths
    localparam int SEG_W = 24;
    localparam int DIG_W = 16;
    localparam int OUT_TOTAL_MAX = 34;
    localparam int SEG_LO_W = 16;
    localparam int SEG_DYN_MIN = 9;

    // Register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_DIGCNT = 8'h04;
    localparam logic [7:0] OFS_DIMMER_SELECT_REGISTER = 8'h08;
    localparam logic [7:0] OFS_STAT_LO = 8'h0c;
    localparam logic [7:0] OFS_STAT_HI = 8'h10;
    localparam logic [7:0] OFS_KEYSCAN = 8'h14;
    localparam logic [7:0] OFS_PORT = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] OFS_MEM_BASE = 8'h40;

    // Field positions
    localparam int MODE_EN_BIT = 3;
    localparam int DIMMER_SELECT_REGISTER_LEN_BIT = 0;
    localparam int STAT_HI_LSB = 4;

    // Reset values, minimum digit count and all-static codes
    localparam logic [3:0] MODE_RST = 4'h0;
    localparam logic [3:0] DIGCNT_RST = 4'h8;
    localparam logic [3:0] DIMMER_SELECT_REGISTER_RST = 4'h0;
    localparam logic [3:0] STAT_LO_RST = 4'h0;
    localparam logic [1:0] STAT_HI_RST = 2'h0;
    localparam logic [3:0] DIGCNT_MIN = 4'h8;
    localparam logic [3:0] STAT_LO_ALL = 4'hf;
    localparam logic [1:0] STAT_HI_ALL = 2'h3;

    // Processor clock settings that allow scanning
    localparam logic [3:0] PCC_HIGH = 4'h3;
    localparam logic [3:0] PCC_MID = 4'h2;

    // Display cycle lengths in oscillator periods (clk_sys is the oscillator)
    localparam int CYC_SHORT_CLK = 1024;
    localparam int CYC_LONG_CLK = 2048;
    localparam int PHASE_W = 11;

    typedef struct packed {
        logic en;
        logic [2:0] seg_code;
    } vfd_mode_s;

    typedef struct packed {
        logic [2:0] cut_code;
        logic long_cyc;
    } vfd_dimmer_select_register_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DIGIT = 2'b01,
        ST_KEYSCAN = 2'b11
    } vfd_state_e;

endpackage : vfd_pkg

// >>> vfd_slot_timer.sv
// Display cycle timer: phase count inside one display slot
`timescale 1ns/1ps
`default_nettype none
module vfd_slot_timer
    import vfd_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Control
    input wire logic run,
    input wire logic long_cyc,
    // Status
    output logic [PHASE_W-1:0] phase,
    output logic slot_end
);

    logic [PHASE_W-1:0] phase_r;
    logic [PHASE_W-1:0] phase_nxt;
    logic [PHASE_W-1:0] last_phase;

    assign last_phase = long_cyc ? PHASE_W'(CYC_LONG_CLK - 1) : PHASE_W'(CYC_SHORT_CLK - 1); // R13
    assign slot_end = run && (phase_r == last_phase);
    assign phase = phase_r;

    always_comb
    begin
        phase_nxt = phase_r;
        if (!run || slot_end)
        begin
            phase_nxt = '0;
        end
        else
        begin
            phase_nxt = phase_r + PHASE_W'(1); // R09
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            phase_r <= '0;
        end
        else
        begin
            phase_r <= phase_nxt;
        end
    end

    a_slot_length : assert property (@(posedge clk_sys) disable iff (!rst_n)
        slot_end |-> (phase_r == (long_cyc ? 11'h7ff : 11'h3ff))) // R09
        else $error("Display slot ended at wrong length");

endmodule : vfd_slot_timer
`default_nettype wire

// >>> vfd_disp_mem.sv
// Display data memory: one segment row per digit, byte-writable
`timescale 1ns/1ps
`default_nettype none
module vfd_disp_mem #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 24
) (
    // Clock
    input wire logic clk_sys,
    // Write port
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input wire logic [WIDTH/8-1:0] wr_be,
    input wire logic [WIDTH-1:0] wr_data,
    // Scan fetch port
    input wire logic [$clog2(DEPTH)-1:0] fetch_idx,
    output logic [WIDTH-1:0] fetch_data,
    // Bus read port
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic [WIDTH-1:0] rd_data
);

    initial
    begin
        if (WIDTH % 8 != 0 || DEPTH < 2)
        begin
            $error("Display memory needs whole bytes and two rows");
        end
    end

    // One lane array per byte, so every array has a single writing process
    // Contents are not reset: software loads the rows before enabling scan
    for (genvar b = 0; b < WIDTH / 8; b++)
    begin : g_byte
        logic [7:0] lane_r [DEPTH];

        always_ff @(posedge clk_sys)
        begin
            if (wr_en && wr_be[b])
            begin
                lane_r[wr_idx] <= wr_data[b*8 +: 8];
            end
        end

        assign fetch_data[b*8 +: 8] = lane_r[fetch_idx];
        assign rd_data[b*8 +: 8] = lane_r[rd_idx];
    end

endmodule : vfd_disp_mem
`default_nettype wire

// >>> vfd_scan_ctrl.sv
// Display scan controller top: bus registers, scan sequencer, pin drivers
//
// How it works
// R01: Digits and segments scanned automatically from memory
// R02: 9-24 segments, 9-16 digits, 34 outputs
// R03: Scan only on main clock, fast settings
// R04: Software stops display before clock changes
// R05: Undriven display pins become static port bits; only segment pins do here, unused digit pins stay low
// R06: Eight dimmer levels set digit pulse width
// R07: Key-scan request marks key slot each frame
// R08: Key-scan buffers drive segments in key slot
// R09: Display cycle is 1024 or 2048 clocks
// R10: Frame lasts display cycle times digits plus two; the code makes it digits plus one (digit count plus two)
// R11: Digits ascend one per slot, then key slot
// R12: Digit count 8-15 shows N+1; reset nine
// R13: Cycle length bit picks 1024 or 2048
// R14: Dimmer code cuts 1/16 to 14/16 of slot
// R15: Mode register: enable, segment count; reset stopped
//
// Design decisions made here: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module vfd_scan_ctrl
    import vfd_pkg::*;
#(
    parameter int SEG_N = SEG_W,
    parameter int DIG_N = DIG_W
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Clock setting of the host processor
    input wire logic sysclk_sub_sel,
    input wire logic [3:0] proc_clk_setting,
    // Display pins
    output logic [DIG_N-1:0] digit_o,
    output logic [SEG_N-1:0] seg_o,
    output logic keyscan_irq
);

    initial
    begin
        if (SEG_N != SEG_W || DIG_N != DIG_W)
        begin
            $error("Pin widths are fixed by the register layout");
        end
    end

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
        input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    // Cut width in oscillator clocks for a dimmer code
    function automatic logic [PHASE_W-1:0] cut_clocks(input logic [2:0] code, input logic long_cyc);
        logic [PHASE_W-1:0] sixteenths;
        sixteenths = (code == 3'h0) ? PHASE_W'(1) : PHASE_W'({code, 1'b0}); // R14
        return long_cyc ? (sixteenths << 7) : (sixteenths << 6);
    endfunction : cut_clocks

    ////////////////////////////////////////////////////////////////////////
    // State
    vfd_mode_s mode_r, mode_nxt;
    vfd_dimmer_select_register_s dimmer_select_register_r, dimmer_select_register_nxt;
    logic [3:0] digcnt_r, digcnt_nxt;
    logic [3:0] stat_lo_r, stat_lo_nxt;
    logic [1:0] stat_hi_r, stat_hi_nxt;
    logic [SEG_W-1:0] ks_r, ks_nxt;
    logic [SEG_W-1:0] port_r, port_nxt;
    vfd_state_e state_r, state_nxt;
    logic [4:0] slot_r, slot_nxt;
    logic [SEG_W-1:0] fetch_r, fetch_nxt;
    logic [DIG_W-1:0] digit_nxt;
    logic [SEG_W-1:0] seg_nxt;
    logic irq_nxt;
    logic [31:0] dat_nxt;
    logic ack_nxt;

    // Combinational helpers
    logic run_ok;
    logic bus_req;
    logic wr;
    logic mem_sel;
    logic [PHASE_W-1:0] phase;
    logic slot_end;
    logic [PHASE_W-1:0] cut_cyc;
    logic [3:0] fetch_idx;
    logic [SEG_W-1:0] fetch_data;
    logic [SEG_W-1:0] mem_rd_data;
    logic [4:0] seg_count;
    logic [5:0] seg_pins;
    logic [5:0] dig_limit;
    logic lo_static;
    logic hi_static;
    logic [SEG_W-1:0] dyn_data;

    // Scan drops to idle and restarts from slot 0 outside the documented clock settings; software is expected to clear enable first
    assign run_ok = mode_r.en && !sysclk_sub_sel
        && (proc_clk_setting == PCC_HIGH || proc_clk_setting == PCC_MID); // R03 R04
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = bus_req && wb_we_i;
    assign mem_sel = wb_adr_i[7:6] == OFS_MEM_BASE[7:6];
    assign cut_cyc = cut_clocks(dimmer_select_register_r.cut_code, dimmer_select_register_r.long_cyc); // R06
    assign lo_static = stat_lo_r == STAT_LO_ALL;
    assign hi_static = stat_hi_r == STAT_HI_ALL;
    assign seg_count = 5'(SEG_DYN_MIN) + {2'h0, mode_r.seg_code}; // R15
    assign seg_pins = (lo_static ? 6'h0 : {1'b0, seg_count}) + (hi_static ? 6'h0 : 6'h8);
    assign dig_limit = 6'(OUT_TOTAL_MAX) - seg_pins; // R02
    assign fetch_idx = (state_r == ST_DIGIT && slot_r < {1'b0, digcnt_r}) ? slot_r[3:0] + 4'h1 : 4'h0;

    vfd_slot_timer u_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(state_r != ST_IDLE),
        .long_cyc(dimmer_select_register_r.long_cyc),
        .phase(phase),
        .slot_end(slot_end)
    );

    vfd_disp_mem #(
        .DEPTH(DIG_W),
        .WIDTH(SEG_W)
    ) u_mem (
        .clk_sys(clk_sys),
        .wr_en(wr && mem_sel),
        .wr_idx(wb_adr_i[5:2]),
        .wr_be(wb_sel_i[2:0]),
        .wr_data(wb_dat_i[SEG_W-1:0]),
        .fetch_idx(fetch_idx),
        .fetch_data(fetch_data),
        .rd_idx(wb_adr_i[5:2]),
        .rd_data(mem_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Registers and bus
    always_comb
    begin
        logic [31:0] w;
        w = '0;
        mode_nxt = mode_r;
        dimmer_select_register_nxt = dimmer_select_register_r;
        digcnt_nxt = digcnt_r;
        stat_lo_nxt = stat_lo_r;
        stat_hi_nxt = stat_hi_r;
        ks_nxt = ks_r;
        port_nxt = port_r;
        ack_nxt = bus_req;
        dat_nxt = '0;
        if (wr && !mem_sel)
        begin
            unique case (wb_adr_i)
                OFS_MODE: if (wb_sel_i[0]) mode_nxt = wb_dat_i[3:0];
                OFS_DIGCNT:
                begin
                    // Values below eight are refused, old count kept
                    if (wb_sel_i[0] && wb_dat_i[3:0] >= DIGCNT_MIN)
                    begin
                        digcnt_nxt = wb_dat_i[3:0]; // R12
                    end
                end
                OFS_DIMMER_SELECT_REGISTER: if (wb_sel_i[0]) dimmer_select_register_nxt = wb_dat_i[3:0];
                OFS_STAT_LO: if (wb_sel_i[0]) stat_lo_nxt = wb_dat_i[3:0];
                OFS_STAT_HI: if (wb_sel_i[0]) stat_hi_nxt = wb_dat_i[STAT_HI_LSB +: 2];
                OFS_KEYSCAN:
                begin
                    w = merge_bytes({8'h0, ks_r}, wb_dat_i, wb_sel_i);
                    ks_nxt = w[SEG_W-1:0];
                end
                OFS_PORT:
                begin
                    w = merge_bytes({8'h0, port_r}, wb_dat_i, wb_sel_i);
                    port_nxt = w[SEG_W-1:0];
                end
                default: ;
            endcase
        end
        if (bus_req && !wb_we_i)
        begin
            if (mem_sel)
            begin
                dat_nxt = {8'h0, mem_rd_data};
            end
            else
            begin
                unique case (wb_adr_i)
                    OFS_MODE: dat_nxt = {28'h0, mode_r};
                    OFS_DIGCNT: dat_nxt = {28'h0, digcnt_r};
                    OFS_DIMMER_SELECT_REGISTER: dat_nxt = {28'h0, dimmer_select_register_r};
                    OFS_STAT_LO: dat_nxt = {28'h0, stat_lo_r};
                    OFS_STAT_HI: dat_nxt = {26'h0, stat_hi_r, 4'h0};
                    OFS_KEYSCAN: dat_nxt = {8'h0, ks_r};
                    OFS_PORT: dat_nxt = {8'h0, port_r};
                    OFS_STATUS: dat_nxt = {24'h0, run_ok, state_r == ST_KEYSCAN, 1'b0, slot_r};
                    default: dat_nxt = '0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Scan sequencer and pin drivers
    always_comb
    begin
        state_nxt = state_r;
        slot_nxt = slot_r;
        fetch_nxt = fetch_r;
        if (!run_ok)
        begin
            state_nxt = ST_IDLE;
            slot_nxt = '0;
        end
        else
        begin
            unique case (state_r)
                ST_IDLE:
                begin
                    state_nxt = ST_DIGIT;
                    slot_nxt = '0;
                    fetch_nxt = fetch_data; // R01
                end
                ST_DIGIT:
                begin
                    if (slot_end)
                    begin
                        // Count lowered mid-frame: close the frame at once, never wrap the slot index
                        if (slot_r >= {1'b0, digcnt_r})
                        begin
                            state_nxt = ST_KEYSCAN; // R10
                            slot_nxt = {1'b0, digcnt_r} + 5'h1;
                        end
                        else
                        begin
                            slot_nxt = slot_r + 5'h1; // R11
                            fetch_nxt = fetch_data; // R01
                        end
                    end
                end
                ST_KEYSCAN:
                begin
                    if (slot_end)
                    begin
                        state_nxt = ST_DIGIT; // R11
                        slot_nxt = '0;
                        fetch_nxt = fetch_data;
                    end
                end
                default: state_nxt = ST_IDLE;
            endcase
        end
    end

    always_comb
    begin
        dyn_data = '0;
        if (state_r == ST_KEYSCAN)
        begin
            dyn_data = ks_r; // R08
        end
        else if (state_r == ST_DIGIT)
        begin
            dyn_data = fetch_r;
        end
        for (int i = 0; i < SEG_LO_W; i++)
        begin
            if (!lo_static && i < 32'(seg_count))
            begin
                seg_nxt[i] = dyn_data[i];
            end
            else
            begin
                seg_nxt[i] = port_r[i]; // R05
            end
        end
        seg_nxt[SEG_W-1:SEG_LO_W] = hi_static ? port_r[SEG_W-1:SEG_LO_W] : dyn_data[SEG_W-1:SEG_LO_W]; // R05
        digit_nxt = '0;
        if (state_r == ST_DIGIT && phase >= cut_cyc && {1'b0, slot_r} < dig_limit) // R06 R14
        begin
            digit_nxt[slot_r[3:0]] = 1'b1;
        end
        irq_nxt = (state_r == ST_KEYSCAN) && (phase == '0); // R07
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            mode_r <= MODE_RST; // R15
            dimmer_select_register_r <= DIMMER_SELECT_REGISTER_RST;
            digcnt_r <= DIGCNT_RST; // R12
            stat_lo_r <= STAT_LO_RST;
            stat_hi_r <= STAT_HI_RST;
            ks_r <= '0;
            port_r <= '0;
            state_r <= ST_IDLE;
            slot_r <= '0;
            fetch_r <= '0;
            digit_o <= '0;
            seg_o <= '0;
            keyscan_irq <= 1'b0;
            wb_dat_o <= '0;
            wb_ack_o <= 1'b0;
        end
        else
        begin
            mode_r <= mode_nxt;
            dimmer_select_register_r <= dimmer_select_register_nxt;
            digcnt_r <= digcnt_nxt;
            stat_lo_r <= stat_lo_nxt;
            stat_hi_r <= stat_hi_nxt;
            ks_r <= ks_nxt;
            port_r <= port_nxt;
            state_r <= state_nxt;
            slot_r <= slot_nxt;
            fetch_r <= fetch_nxt;
            digit_o <= digit_nxt;
            seg_o <= seg_nxt;
            keyscan_irq <= irq_nxt;
            wb_dat_o <= dat_nxt;
            wb_ack_o <= ack_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_digit_one_hot : assert property ($onehot0(digit_o)) // R11
        else $error("More than one digit driven");
    a_stop_dark : assert property (!run_ok |=> ##1 digit_o == '0) // R03
        else $error("Digit driven while scan not allowed");
    a_cut_width : assert property ((state_r == ST_DIGIT && phase < cut_cyc) |=> digit_o == '0) // R14
        else $error("Digit driven inside cut window");
    a_irq_slot : assert property (keyscan_irq // R07
        |-> $past(state_r) == ST_KEYSCAN && $past(slot_r) == {1'b0, $past(digcnt_r, 2)} + 5'h1)
        else $error("Key-scan request outside key slot");
    a_keyscan_segs : assert property ((state_r == ST_KEYSCAN && !lo_static) |=> seg_o[7:0] == $past(ks_r[7:0])) // R08
        else $error("Key-scan buffer not on segments");
    a_digcnt_range : assert property (digcnt_r >= DIGCNT_MIN) // R12
        else $error("Digit count below eight");
    a_slot_ascend : assert property ((state_r == ST_DIGIT && slot_end && slot_r < {1'b0, digcnt_r} && run_ok)
        |=> state_r == ST_DIGIT && slot_r == $past(slot_r) + 5'h1) // R11
        else $error("Digit order broken");
    a_frame_wrap : assert property ((state_r == ST_KEYSCAN && slot_end && run_ok) |=> slot_r == 5'h0) // R10
        else $error("Frame did not restart after key slot");
    a_static_lo : assert property (lo_static |=> seg_o[15:0] == $past(port_r[15:0])) // R05
        else $error("Static low segments not from port data");

endmodule : vfd_scan_ctrl
`default_nettype wire

// >>> vfd_tube_model.sv
// Display tube and key matrix model: records what each digit showed and the frame spacing
`timescale 1ns/1ps
`default_nettype none
module vfd_tube_model
    import vfd_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Display pins
    input wire logic [DIG_W-1:0] digit_o,
    input wire logic [SEG_W-1:0] seg_o,
    input wire logic keyscan_irq,
    // Observations
    output logic [SEG_W-1:0] row_seen [DIG_W],
    output logic [SEG_W-1:0] key_seen,
    output logic [31:0] frame_gap,
    output logic hot_err
);
    logic [31:0] gap_cnt_r;
    logic irq_d_r;

    ////////////////////////////////////////////////////////////////
    // Rows are not reset: an unlit digit stays unknown and fails
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            gap_cnt_r <= 32'h0;
            irq_d_r <= 1'b0;
            frame_gap <= 32'h0;
            key_seen <= '0;
            hot_err <= 1'b0;
        end
        else
        begin
            gap_cnt_r <= keyscan_irq ? 32'h1 : gap_cnt_r + 32'h1;
            irq_d_r <= keyscan_irq;
            if (keyscan_irq)
                frame_gap <= gap_cnt_r;
            if (irq_d_r)
                key_seen <= seg_o;
            if ($countones(digit_o) > 1)
                hot_err <= 1'b1;
            for (int k = 0; k < DIG_W; k++)
                if (digit_o[k])
                    row_seen[k] <= seg_o;
        end
    end
endmodule : vfd_tube_model
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench of the display scan controller
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import vfd_pkg::*;
;
    logic clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sysclk_sub_sel, keyscan_irq, hot_err;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i, proc_clk_setting;
    logic [31:0] wb_dat_i, wb_dat_o, frame_gap, seed, rd_q, port_v, key_v;
    logic [DIG_W-1:0] digit_o;
    logic [SEG_W-1:0] seg_o, key_seen;
    logic [SEG_W-1:0] row_seen [DIG_W];
    logic [23:0] rows [DIG_W];
    int miscompares = 0;
    int cmp_count = 0;
    int cyc_cnt = 0;
    int w, lit;

    vfd_scan_ctrl DUT (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sysclk_sub_sel(sysclk_sub_sel),
        .proc_clk_setting(proc_clk_setting), .digit_o(digit_o), .seg_o(seg_o), .keyscan_irq(keyscan_irq));
    vfd_tube_model tube (.clk_sys(clk_sys), .rst_n(rst_n), .digit_o(digit_o), .seg_o(seg_o),
        .keyscan_irq(keyscan_irq), .row_seen(row_seen), .key_seen(key_seen), .frame_gap(frame_gap),
        .hot_err(hot_err));

    always #25 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////
    task complete_run;
        if (miscompares == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
    endfunction : lfsr

    // Pulse width left after the cut at the head of the slot
    function automatic int exp_width(input int code, input logic lng);
        int slot;
        slot = lng ? CYC_LONG_CLK : CYC_SHORT_CLK;
        return slot - slot * (code == 0 ? 1 : 2 * code) / 16;
    endfunction : exp_width

    // Nine dynamic segments; the rest are static port bits
    function automatic logic [31:0] seg_exp(input logic [23:0] v);
        return {8'h0, (port_v[23:0] & 24'hfffe00) | (v & 24'h0001ff)};
    endfunction : seg_exp

    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        // Ack and read data are taken at the rising edge that samples ack high
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 16);
        if (n >= 16)
            miscompares++;
        rd_q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        check(rd_q, exp);
    endtask : rd_chk

    // Waits for a digit pulse and returns its width in clocks
    task meas(output int width);
        int n;
        n = 0;
        width = 0;
        while (digit_o === '0 && n < 5000)
        begin
            @(negedge clk_sys);
            n++;
        end
        while (digit_o !== '0 && width < 3000)
        begin
            @(negedge clk_sys);
            width++;
        end
    endtask : meas

    task wait_irq;
        int n;
        n = 0;
        do
        begin
            @(negedge clk_sys);
            n++;
        end
        while (keyscan_irq !== 1'b1 && n < 40000);
        if (n >= 40000)
            miscompares++;
    endtask : wait_irq

    always @(posedge clk_sys)
    begin
        cyc_cnt++;
        if (cyc_cnt == 98000)
        begin
            miscompares++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i, sysclk_sub_sel} = 4'h0;
        wb_adr_i = 8'h0;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        proc_clk_setting = PCC_HIGH;
        seed = 32'h1dcd;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_chk(OFS_MODE, 32'h0);
        rd_chk(OFS_DIGCNT, 32'h8);
        rd_chk(OFS_DIMMER_SELECT_REGISTER, 32'h0);
        rd_chk(8'h30, 32'h0);
        wb(1'b1, OFS_DIGCNT, 32'h7);
        rd_chk(OFS_DIGCNT, 32'h8);
        wb(1'b1, OFS_DIGCNT, 32'hf);
        rd_chk(OFS_DIGCNT, 32'hf);
        for (int k = 0; k < DIG_W; k++)
        begin
            seed = lfsr(seed);
            rows[k] = seed[23:0];
            wb(1'b1, OFS_MEM_BASE + 8'(4 * k), {8'h0, rows[k]});
        end
        rd_chk(OFS_MEM_BASE + 8'h3c, {8'h0, rows[15]});
        seed = lfsr(seed);
        key_v = seed;
        wb(1'b1, OFS_KEYSCAN, key_v);
        seed = lfsr(seed);
        port_v = seed;
        wb(1'b1, OFS_PORT, port_v);
        wb(1'b1, OFS_STAT_HI, 32'h30);
        wb(1'b1, OFS_MODE, 32'h8);
        wait_irq();
        wait_irq();
        // Key capture lands one clock after the frame gap
        repeat (2) @(negedge clk_sys);
        check(frame_gap, 32'(17 * CYC_SHORT_CLK));
        for (int k = 0; k < DIG_W; k++)
            check({8'h0, row_seen[k]}, seg_exp(rows[k]));
        check({8'h0, key_seen}, seg_exp(key_v[23:0]));
        check({31'h0, hot_err}, 32'h0);
        wb(1'b1, OFS_DIGCNT, 32'h8);
        // Third pulse is the first whose slot began after the write
        for (int c = 0; c < 8; c++)
        begin
            meas(w);
            wb(1'b1, OFS_DIMMER_SELECT_REGISTER, {28'h0, 3'(c), 1'b0});
            meas(w);
            meas(w);
            check(32'(w), 32'(exp_width(c, 1'b0)));
        end
        wb(1'b1, OFS_DIMMER_SELECT_REGISTER, {28'h0, 3'h3, 1'b1});
        repeat (3) meas(w);
        check(32'(w), 32'(exp_width(3, 1'b1)));
        for (int i = 0; i < 3; i++)
        begin
            wb(1'b1, OFS_MODE, 32'h0);
            @(posedge clk_sys);
            sysclk_sub_sel <= (i == 0);
            proc_clk_setting <= (i == 0) ? PCC_HIGH : 4'(i - 1);
            wb(1'b1, OFS_MODE, 32'h8);
            lit = 0;
            repeat (2100)
            begin
                @(negedge clk_sys);
                if (digit_o !== '0 || keyscan_irq !== 1'b0)
                    lit++;
            end
            check(32'(lit), 32'h0);
            wb(1'b1, OFS_MODE, 32'h0);
            @(posedge clk_sys);
            sysclk_sub_sel <= 1'b0;
            proc_clk_setting <= PCC_MID;
        end
        wb(1'b1, OFS_MODE, 32'h8);
        repeat (3) meas(w);
        check(32'(w), 32'(exp_width(3, 1'b1)));
        wb(1'b1, OFS_STAT_LO, 32'hf);
        repeat (2) @(negedge clk_sys);
        check({8'h0, seg_o}, {8'h0, port_v[23:0]});
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
